// ==== design/seq_pkg.sv ====
package seq_pkg;

    // ****************************************************************
    // channel count and counter width
    // ****************************************************************
    localparam int NUM_CH = 4;
    localparam int CNT_W  = 32;

    // ****************************************************************
    // timing figures, clock rate and derived cycle counts
    // ****************************************************************
    localparam int CLK_PERIOD_NS    = 50;
    localparam int DLY_MIN_NS       = 40000;
    localparam int DISCHARGE_NS     = 40000;
    localparam int PGT_BASE_NS      = 5000;
    localparam int FAULT_PULSE_NS   = 80000;
    localparam int RESET_TIMEOUT_MS = 100;
    localparam int NS_PER_PF        = 125;   // 125 kohm times one picofarad

    localparam int DISCHARGE_CYC = (DISCHARGE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAULT_PULSE_CYC = (FAULT_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int RESET_TIMEOUT_CYC = (RESET_TIMEOUT_MS * 1000000) / CLK_PERIOD_NS;

    // ****************************************************************
    // reset values and index encoding
    // ****************************************************************
    localparam logic [3:0] CH_NONE  = 4'h0;
    localparam logic [2:0] NONE_IDX = 3'h4;   // bit 2 set: no channel found

    // ****************************************************************
    // sequencer states, one-hot
    // ****************************************************************
    typedef enum logic [8:0] {
        S_INIT    = 9'h001,
        S_IDLE    = 9'h002,
        S_UP_DLY  = 9'h004,
        S_UP_PG   = 9'h008,
        S_RST     = 9'h010,
        S_ON      = 9'h020,
        S_DN_DLY  = 9'h040,
        S_DN_WAIT = 9'h080,
        S_FAULT   = 9'h100
    } seq_state_t;

    // delay is the larger of the floor and the capacitor charge time
    function automatic int dly_cycles(input int cap_pf);
        int ns;
        ns = (NS_PER_PF * cap_pf > DLY_MIN_NS) ? NS_PER_PF * cap_pf : DLY_MIN_NS;
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction : dly_cycles

    // power-good window is a fixed base plus the capacitor charge time
    function automatic int pgt_cycles(input int cap_pf);
        int ns;
        ns = PGT_BASE_NS + NS_PER_PF * cap_pf;
        return (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    endfunction : pgt_cycles

endpackage : seq_pkg

// ==== design/cycle_timer.sv ====
`timescale 1ns/1ps
module cycle_timer
    import seq_pkg::*;
(
    input  wire logic             clk_i,
    input  wire logic             arst_n_i,
    input  wire logic             run_i,
    input  wire logic [CNT_W-1:0] limit_i,
    output logic                  expired_o
);
    logic [CNT_W-1:0] cnt;

    // expired from the limit-th cycle of run onward; a limit of 0 acts as 1
    assign expired_o = run_i && ((cnt + CNT_W'(1)) >= limit_i);

    // counts while running, saturates at expiry, clears when run drops
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cnt <= '0;
        end else if (!run_i) begin
            cnt <= '0;
        end else if (!expired_o) begin
            cnt <= cnt + CNT_W'(1);
        end
    end
endmodule : cycle_timer

// ==== design/input_edge.sv ====
`timescale 1ns/1ps
module input_edge (
    input  wire logic clk_i,
    input  wire logic arst_n_i,
    input  wire logic level_i,
    output logic      rise_o,
    output logic      fall_o
);
    logic prev;

    // comparator output is already digital; only its change matters
    assign rise_o = level_i && !prev;
    assign fall_o = !level_i && prev;

    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prev <= 1'b0;
        end else begin
            prev <= level_i;
        end
    end
endmodule : input_edge

// ==== design/power_sequencer.sv ====
`timescale 1ns/1ps
// Behaviour
// - init marks channels with high feedback skipped
// - skipped channels get no delay, timer, fault
// - all skipped gives done and power ok
// - skip decisions redone after every fault
// - turn-on and turn-off act on edges
// - turn-on rising edge starts power-on
// - turn-off falling edge starts reverse power-down
// - other edges of both inputs ignored
// - turn-on drop or re-rise mid-sequence faults
// - delay timer runs then next channel enables
// - delay scales with capacitance, forty microsecond floor
// - delay timer discharges before timing again
// - missed power-good window raises fault
// - feedback crossing stops timer, proceed at once
// - power-good timer only during power-on
// - power-good window base plus capacitance term
// - any fault pulls shared fault line low
// - enable each channel one delay after previous
// - disable each one delay after following drops
// - one-shot fault pulse, undervoltage holds low
// - external fault line low forces all off
module power_sequencer
    import seq_pkg::*;
#(
    parameter int DELAY_CAP_PF  = 0,
    parameter int PGT_CAP_PF    = 0,
    parameter int RESET_TIMEOUT = RESET_TIMEOUT_CYC
) (
    input  wire logic        CLK_SYS_I,
    input  wire logic        ARST_N_I,
    input  wire logic        TURN_ON_I,
    input  wire logic        TURN_OFF_N_I,
    input  wire logic [3:0]  FEEDBACK_I,
    input  wire logic        UNDERVOLTAGE_I,
    input  wire logic        FAULT_N_I,
    output logic             FAULT_N_O,
    output logic             FAULT_N_OE_O,
    output logic [3:0]       SUPPLY_EN_O,
    output logic [3:0]       CHANNEL_SKIP_O,
    output logic             DONE_O,
    output logic             POWER_OK_O
);

    // ****************************************************************
    // timer limits
    // ****************************************************************
    localparam logic [CNT_W-1:0] DLY_LIM = CNT_W'(dly_cycles(DELAY_CAP_PF));
    localparam logic [CNT_W-1:0] PGT_LIM = CNT_W'(pgt_cycles(PGT_CAP_PF));
    localparam logic [CNT_W-1:0] DIS_LIM = CNT_W'(DISCHARGE_CYC);
    // one extra count: the expiry cycle itself no longer drives the line
    localparam logic [CNT_W-1:0] PUL_LIM = CNT_W'(FAULT_PULSE_CYC + 1);
    localparam logic [CNT_W-1:0] RST_LIM = CNT_W'(RESET_TIMEOUT);

    // ****************************************************************
    // state and registers
    // ****************************************************************
    seq_state_t state;
    seq_state_t next_state;
    logic [3:0] skip;
    logic [3:0] en;
    logic [3:0] mon;
    logic [1:0] cur;
    logic       done;
    logic       power_ok_output;
    logic       discharging;
    logic       uv_flag;

    // lowest unskipped channel at or above a start index
    function automatic logic [2:0] pick_up(input logic [3:0] m, input logic [2:0] from);
        logic [2:0] r;
        r = NONE_IDX;
        for (int i = NUM_CH - 1; i >= 0; i--) begin
            if (!m[i] && (3'(i) >= from)) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : pick_up

    // highest unskipped channel at or below a start index
    function automatic logic [2:0] pick_dn(input logic [3:0] m, input logic [2:0] from);
        logic [2:0] r;
        r = NONE_IDX;
        for (int i = 0; i < NUM_CH; i++) begin
            if (!m[i] && (3'(i) <= from)) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : pick_dn

    // ****************************************************************
    // input edges
    // ****************************************************************
    wire on_rise;
    wire off_fall;

    // only the rising turn-on and falling turn-off edges are used
    input_edge u_on_edge (
        .clk_i    (CLK_SYS_I),
        .arst_n_i (ARST_N_I),
        .level_i  (TURN_ON_I),
        .rise_o   (on_rise),
        .fall_o   ()
    );

    input_edge u_off_edge (
        .clk_i    (CLK_SYS_I),
        .arst_n_i (ARST_N_I),
        .level_i  (TURN_OFF_N_I),
        .rise_o   (),
        .fall_o   (off_fall)
    );

    // ****************************************************************
    // state decode and channel selection
    // ****************************************************************
    wire st_init   = (state == S_INIT);
    wire st_idle   = (state == S_IDLE);
    wire st_up_dly = (state == S_UP_DLY);
    wire st_up_pg  = (state == S_UP_PG);
    wire st_rst    = (state == S_RST);
    wire st_on     = (state == S_ON);
    wire st_dn_dly = (state == S_DN_DLY);
    wire st_dn_wt  = (state == S_DN_WAIT);
    wire st_fault  = (state == S_FAULT);

    wire       fb_cur   = FEEDBACK_I[cur];
    wire       all_skip = &skip;
    wire [2:0] up_first = pick_up(skip, 3'h0);
    wire [2:0] up_next  = pick_up(skip, {1'b0, cur} + 3'h1);
    wire [2:0] dn_first = pick_dn(skip, 3'h3);
    wire [2:0] dn_next  = (cur == 2'h0) ? NONE_IDX : pick_dn(skip, {1'b0, cur} - 3'h1);

    // ****************************************************************
    // timers
    // ****************************************************************
    wire dly_exp;
    wire dis_exp;
    wire pgt_exp;
    wire rst_exp;
    wire pul_exp;

    // delay may not restart until the previous discharge has finished
    wire dly_run = (st_up_dly || st_dn_dly) && !discharging;

    cycle_timer u_dly (
        .clk_i     (CLK_SYS_I),
        .arst_n_i  (ARST_N_I),
        .run_i     (dly_run),
        .limit_i   (DLY_LIM),
        .expired_o (dly_exp)
    );

    cycle_timer u_dis (
        .clk_i     (CLK_SYS_I),
        .arst_n_i  (ARST_N_I),
        .run_i     (discharging),
        .limit_i   (DIS_LIM),
        .expired_o (dis_exp)
    );

    // power-good window runs only while waiting for a rising channel
    cycle_timer u_pgt (
        .clk_i     (CLK_SYS_I),
        .arst_n_i  (ARST_N_I),
        .run_i     (st_up_pg),
        .limit_i   (PGT_LIM),
        .expired_o (pgt_exp)
    );

    cycle_timer u_rst (
        .clk_i     (CLK_SYS_I),
        .arst_n_i  (ARST_N_I),
        .run_i     (st_rst),
        .limit_i   (RST_LIM),
        .expired_o (rst_exp)
    );

    cycle_timer u_pul (
        .clk_i     (CLK_SYS_I),
        .arst_n_i  (ARST_N_I),
        .run_i     (st_fault),
        .limit_i   (PUL_LIM),
        .expired_o (pul_exp)
    );

    // ****************************************************************
    // fault detection
    // ****************************************************************
    // mid-sequence turn-on must stay high; a drop or re-rise aborts
    wire seq_active  = st_up_dly || st_up_pg;
    wire seq_fault   = seq_active && (!TURN_ON_I || on_rise);
    // feedback wins over a timer expiring in the same cycle
    wire pgt_fault   = st_up_pg && pgt_exp && !fb_cur;
    wire mon_fail    = |(mon & ~FEEDBACK_I);
    wire uv_hit      = UNDERVOLTAGE_I && (st_rst || st_on);
    wire ext_fault   = !FAULT_N_I;
    wire fault_req   = !st_fault &&
                       (ext_fault || mon_fail || uv_hit || seq_fault || pgt_fault);
    // undervoltage holds the line; every other cause gives a one-shot
    wire fault_drive = st_fault && (uv_flag ? UNDERVOLTAGE_I : !pul_exp);
    wire fault_done  = st_fault && !fault_drive && FAULT_N_I;

    // ****************************************************************
    // next-state logic
    // ****************************************************************
    always_comb begin
        next_state = state;
        unique case (state)
            S_INIT: begin
                next_state = (&FEEDBACK_I) ? S_ON : S_IDLE;
            end
            S_IDLE: begin
                if (on_rise) begin
                    next_state = up_first[2] ? S_ON : S_UP_DLY;
                end
            end
            S_UP_DLY: begin
                if (dly_exp) begin
                    next_state = S_UP_PG;
                end
            end
            S_UP_PG: begin
                if (fb_cur) begin
                    next_state = up_next[2] ? S_RST : S_UP_DLY;
                end
            end
            S_RST: begin
                if (rst_exp) begin
                    next_state = S_ON;
                end
            end
            S_ON: begin
                if (off_fall) begin
                    next_state = dn_first[2] ? S_IDLE : S_DN_DLY;
                end
            end
            S_DN_DLY: begin
                if (dly_exp) begin
                    next_state = dn_next[2] ? S_IDLE : S_DN_WAIT;
                end
            end
            S_DN_WAIT: begin
                if (!fb_cur) begin
                    next_state = S_DN_DLY;
                end
            end
            S_FAULT: begin
                if (fault_done) begin
                    next_state = S_INIT;
                end
            end
            default: begin
                next_state = S_INIT;
            end
        endcase
        if (fault_req) begin
            next_state = S_FAULT;
        end
    end

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            state <= S_INIT;
        end else begin
            state <= next_state;
        end
    end

    // ****************************************************************
    // channel pointer and skip mask
    // ****************************************************************
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            cur  <= 2'h0;
            skip <= CH_NONE;
        end else begin
            if (st_init) begin
                skip <= FEEDBACK_I;
            end
            if (st_idle && on_rise) begin
                cur <= up_first[1:0];
            end else if (st_up_pg && fb_cur && !up_next[2]) begin
                cur <= up_next[1:0];
            end else if (st_on && off_fall) begin
                cur <= dn_first[1:0];
            end else if (st_dn_wt && !fb_cur) begin
                cur <= dn_next[1:0];
            end
        end
    end

    // ****************************************************************
    // enables and supervision mask
    // ****************************************************************
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            en  <= CH_NONE;
            mon <= CH_NONE;
        end else if (fault_req || st_fault) begin
            en  <= CH_NONE;
            mon <= CH_NONE;
        end else begin
            if (st_up_dly && dly_exp) begin
                en[cur] <= 1'b1;
            end
            if (st_up_pg && fb_cur) begin
                mon[cur] <= 1'b1;
            end
            if (st_dn_dly && dly_exp) begin
                en[cur]  <= 1'b0;
                mon[cur] <= 1'b0;
            end
        end
    end

    // ****************************************************************
    // done and power ok
    // ****************************************************************
    wire set_done = (st_init && (&FEEDBACK_I)) || (st_idle && on_rise && up_first[2]) ||
                    (st_up_pg && fb_cur && up_next[2]);
    wire clr_done = (st_dn_dly && dly_exp && dn_next[2]) || (st_on && off_fall && dn_first[2]);
    wire set_pok  = (st_init && (&FEEDBACK_I)) || (st_idle && on_rise && up_first[2]) ||
                    rst_exp;

    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            done <= 1'b0;
            power_ok_output  <= 1'b0;
        end else if (fault_req || st_fault) begin
            done <= 1'b0;
            power_ok_output  <= 1'b0;
        end else begin
            done <= (done || set_done) && !clr_done;
            power_ok_output  <= (power_ok_output || set_pok) && !(st_on && off_fall);
        end
    end

    // ****************************************************************
    // discharge interval and fault cause
    // ****************************************************************
    always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
        if (!ARST_N_I) begin
            discharging <= 1'b0;
            uv_flag     <= 1'b0;
        end else begin
            if (dly_exp) begin
                discharging <= 1'b1;
            end else if (dis_exp) begin
                discharging <= 1'b0;
            end
            if (fault_req) begin
                uv_flag <= uv_hit;
            end
        end
    end

    // ****************************************************************
    // outputs
    // ****************************************************************
    assign FAULT_N_O      = 1'b0;
    assign FAULT_N_OE_O   = fault_drive;
    assign SUPPLY_EN_O    = en;
    assign CHANNEL_SKIP_O = skip;
    assign DONE_O         = done;
    assign POWER_OK_O     = power_ok_output;

    // ****************************************************************
    // checks
    // ****************************************************************
    default clocking cb @(posedge CLK_SYS_I); endclocking
    default disable iff (!ARST_N_I);

    a_skip_sampled: assert property (st_init |=> skip == $past(FEEDBACK_I))
        else $error("skip mask not taken from feedback in init");
    a_skip_unused: assert property ((skip & (en | mon)) == CH_NONE)
        else $error("skipped channel enabled or supervised");
    a_all_skip_done: assert property (st_init && (&FEEDBACK_I) && FAULT_N_I |=> done && power_ok_output)
        else $error("all-skip did not raise done and power ok");
    a_on_rise_start: assert property (st_idle && on_rise && FAULT_N_I && !up_first[2]
                                      |=> st_up_dly)
        else $error("turn-on edge did not start sequencing");
    a_seq_abort: assert property (seq_active && !TURN_ON_I |=> st_fault && en == CH_NONE)
        else $error("turn-on drop did not abort sequencing");
    a_enable_delay: assert property (|(en & ~$past(en)) |-> $past(dly_exp))
        else $error("channel enabled without delay expiry");
    a_pgt_timeout: assert property (pgt_fault |=> st_fault ##1 FAULT_N_OE_O)
        else $error("power-good timeout did not raise fault");
    a_pgt_down_idle: assert property ((st_dn_dly || st_dn_wt) && FAULT_N_I
                                      && !mon_fail |-> !pgt_exp ##1 !st_fault)
        else $error("power-good timer active during power-down");
    a_fault_off: assert property (st_fault |-> en == CH_NONE && !done && !power_ok_output)
        else $error("outputs not off in fault");
    a_fault_pulse: assert property ($rose(st_fault) && !uv_flag |-> FAULT_N_OE_O[*8])
        else $error("fault one-shot too short");
    a_ext_fault: assert property (!st_fault && !FAULT_N_I |=> st_fault)
        else $error("external fault not honoured");

endmodule : power_sequencer

// ==== bench/supply_model.sv ====
`timescale 1ns/1ps
// ****************************************************************
// supply rails and feedback comparators
// ****************************************************************
module supply_model (
    input  wire logic       clk_i,
    input  wire logic       arst_n_i,
    input  wire logic [3:0] en_i,
    input  wire logic       dead_i,
    input  wire logic [3:0] stuck_i,
    output logic [3:0]      fb_o
);
    logic [3:0] d1, d2, d3;
    // rails ramp and collapse three cycles after their enable moves;
    // reset empties the pipe so the first init sample never sees unknowns
    always_ff @(posedge clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            d1 <= 4'h0;
            d2 <= 4'h0;
            d3 <= 4'h0;
        end else begin
            d1 <= en_i;
            d2 <= d1;
            d3 <= d2;
        end
    end
    // a dead rail never comes up; a stuck rail reads high, as if tied to the regulator
    assign fb_o = (d3 & ~{4{dead_i}}) | stuck_i;
endmodule : supply_model

// ==== bench/power_sequencer_tb_top.sv ====
`timescale 1ns/1ps
module power_sequencer_tb_top;
    import seq_pkg::*;
    logic       clk, arst_n, on, off_n, ext, dead, fo, foe, done, power_ok_output, uv;
    logic [3:0] stuck, fb, en, skip;
    int         err_count, tests_run;
    // shared fault line with pull-up: low while anyone pulls it
    wire        fault_n = ~(foe | ext);

    power_sequencer #(.RESET_TIMEOUT(20)) dut (.CLK_SYS_I(clk), .ARST_N_I(arst_n),
        .TURN_ON_I(on), .TURN_OFF_N_I(off_n), .FEEDBACK_I(fb), .UNDERVOLTAGE_I(uv),
        .FAULT_N_I(fault_n), .FAULT_N_O(fo), .FAULT_N_OE_O(foe), .SUPPLY_EN_O(en),
        .CHANNEL_SKIP_O(skip), .DONE_O(done), .POWER_OK_O(power_ok_output));
    supply_model rails (.clk_i(clk), .arst_n_i(arst_n), .en_i(en), .dead_i(dead),
        .stuck_i(stuck), .fb_o(fb));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    task step();
        @(posedge clk);
        #5;
    endtask : step
    task report_and_stop();
        $display("checks %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : report_and_stop
    task chk(string name, logic [3:0] seen, logic [3:0] exp);
        tests_run++;
        if (seen !== exp) begin
            $display("Error %s expected %h seen %h", name, exp, seen);
            err_count++;
        end
    endtask : chk
    function logic pick(int k);
        return (k == 0) ? done : (k == 1) ? power_ok_output : foe;
    endfunction : pick
    // bounded polls: running out is a mismatch and ends the run
    task wait_en(logic [3:0] exp, output int n);
        n = 0;
        while (en !== exp) begin
            step();
            n++;
            if (n > 3000) begin
                chk("enables", en, exp);
                report_and_stop();
            end
        end
    endtask : wait_en
    task wait_bit(int k, logic v, int lim);
        int n;
        n = 0;
        while (pick(k) !== v) begin
            step();
            n++;
            if (n > lim) begin
                chk("status", pick(k), v);
                report_and_stop();
            end
        end
    endtask : wait_bit

    // ****************************************************************
    // scenarios
    // ****************************************************************
    task run_up(logic [3:0] m);
        logic [3:0] acc;
        int         n;
        int         k;
        acc = 4'h0;
        k = 0;
        on = 1'b1;
        for (int i = 0; i < 4; i++) begin
            if (!m[i]) begin
                acc[i] = 1'b1;
                k++;
                wait_en(acc, n);
                if (k == 1) chk("first delay", 4'(n >= 800 && n <= 805), 4'h1);
            end
        end
        chk("skip", skip, m);
        wait_bit(0, 1'b1, 20);
        chk("power ok early", 4'(power_ok_output), 4'h0);
        wait_bit(1, 1'b1, 30);
        $display("power-up done");
    endtask : run_up
    task run_down(logic [3:0] m);
        logic [3:0] acc;
        int         n;
        acc = ~m;
        off_n = 1'b0;
        step();
        step();
        chk("power ok drop", 4'(power_ok_output), 4'h0);
        for (int i = 3; i >= 0; i--) begin
            if (!m[i]) begin
                acc[i] = 1'b0;
                wait_en(acc, n);
            end
        end
        chk("done drop", 4'(done), 4'h0);
        off_n = 1'b1;
        on = 1'b0;
        repeat (50) step();
        chk("ignored edges", en, 4'h0);
        $display("power-down done");
    endtask : run_down
    task pg_miss();
        int n;
        dead = 1'b1;
        stuck = 4'h0;
        on = 1'b1;
        wait_en(4'h1, n);
        wait_bit(2, 1'b1, 150);
        chk("miss enables", en, 4'h0);
        on = 1'b0;
        wait_bit(2, 1'b0, 2000);
        dead = 1'b0;
        repeat (3) step();
        chk("skip resampled", skip, 4'h0);
        $display("power-good miss done");
    endtask : pg_miss
    task on_drop();
        int n;
        on = 1'b1;
        wait_en(4'h1, n);
        repeat (20) step();
        on = 1'b0;
        repeat (2) step();
        chk("drop fault", 4'(foe), 4'h1);
        chk("drop enables", en, 4'h0);
        wait_bit(2, 1'b0, 2000);
        // let init finish so the next turn-on rise is seen in idle
        repeat (3) step();
        $display("turn-on drop done");
    endtask : on_drop
    task ext_fault();
        stuck = 4'hF;
        ext = 1'b1;
        repeat (2) step();
        chk("external enables", en, 4'h0);
        chk("external done", 4'(done), 4'h0);
        ext = 1'b0;
        wait_bit(2, 1'b0, 2000);
        wait_bit(0, 1'b1, 10);
        wait_bit(1, 1'b1, 5);
        chk("all skipped", skip, 4'hF);
        $display("external fault done");
    endtask : ext_fault
    // undervoltage in the on state holds the line past the one-shot length
    task uv_hold();
        uv = 1'b1;
        repeat (2) step();
        chk("uv fault", 4'(foe), 4'h1);
        chk("uv power ok", 4'(power_ok_output), 4'h0);
        chk("fault data", 4'(fo), 4'h0);
        repeat (1700) step();
        chk("uv hold", 4'(foe), 4'h1);
        uv = 1'b0;
        step();
        chk("uv release", 4'(foe), 4'h0);
        wait_bit(1, 1'b1, 10);
        $display("undervoltage hold done");
    endtask : uv_hold

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        err_count = 0;
        tests_run = 0;
        arst_n = 1'b0;
        on = 1'b0;
        off_n = 1'b1;
        ext = 1'b0;
        dead = 1'b0;
        uv = 1'b0;
        stuck = 4'h2;
        repeat (2) @(posedge clk);
        #5 arst_n = 1'b1;
        step();
        step();
        run_up(4'h2);
        run_down(4'h2);
        pg_miss();
        on_drop();
        run_up(4'h0);
        ext_fault();
        uv_hold();
        report_and_stop();
    end
endmodule : power_sequencer_tb_top
